// ==== verilog/adc_seq_ctrl.sv ====
// Sample timing and sequencing controller of a 10-bit SAR converter,
// with its control and status words behind an APB slave.
// Assumes triggers and the SAR result are synchronous to pclk, and that
// pclk is the conversion clock.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module adc_seq_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Trigger sources
  input wire logic [2:0] timer_trigger,
  // Analog core and input multiplexer
  input wire logic [9:0] sar_result,
  output logic sample_control,
  output logic [15:0] channel_connect,
  output logic conversion_active,
  // Status
  output logic result_ready_flag,
  output logic busy
);

  adc_seq_pkg::state_t s;
  adc_seq_pkg::state_t n;
  logic sample_trigger_input;
  logic trig_rise;
  logic trig_fall;
  logic abort;
  logic msc_active;
  logic can_start;
  logic last_step;
  logic wr_done;
  logic rd_done;
  logic landing;

  // One-hot switch pattern for a channel pointer.
  function automatic logic [15:0] onehot(input logic [3:0] ch);
    onehot = 16'h0001 << ch;
  endfunction

  // Sampling clocks selected by the sample time field.
  function automatic logic [7:0] sample_cycles(input logic [3:0] sel);
    sample_cycles = 8'((8'({4'h0, sel}) + 8'h01) * adc_seq_pkg::SHT_STEP);
  endfunction

  // Chosen trigger source with the polarity applied.
  always_comb begin
    if (s.src == adc_seq_pkg::SRC_SOFTWARE) begin
      sample_trigger_input = s.sw ^ s.inv;
    end else begin
      sample_trigger_input = timer_trigger[2'(s.src - 2'h1)] ^ s.inv;
    end
  end

  // Edge detection looks only at the second and third stages.
  assign trig_rise = s.ts2 && !s.ts3;
  assign trig_fall = !s.ts2 && s.ts3;
  // Off, or mode zero with enable cleared, drops all activity at once.
  assign abort = !s.on ||
                 (s.mode == adc_seq_pkg::MODE_SINGLE && !s.enc);
  assign msc_active = s.msc && s.mode != adc_seq_pkg::MODE_SINGLE &&
                      s.shp;
  // A fresh start needs enable, no lockout and a rearm for timer triggers.
  assign can_start = s.enc && !s.lock &&
                     (s.armed || s.src == adc_seq_pkg::SRC_SOFTWARE);
  assign last_step = !s.mode[0] || s.chan == 4'h0;
  assign wr_done = psel && penable && s.pready && pwrite;
  assign rd_done = psel && penable && s.pready && !pwrite;
  // A result lands at the edge that ends the last conversion clock.
  assign landing = s.fsm == adc_seq_pkg::ST_CONVERT && s.cnt == 8'h00;

  // Next state of the whole controller.
  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // Trigger synchroniser toward the conversion clock.
    n.ts1 = sample_trigger_input;
    n.ts2 = s.ts1;
    n.ts3 = s.ts2;
    // Enable cleared rearms timer triggers and releases the lockout.
    if (!s.enc) begin
      n.armed = 1'b1;
      n.lock = 1'b0;
      n.sw = 1'b0;
    end
    case (s.fsm)
      adc_seq_pkg::ST_OFF: begin
        if (s.on) begin
          n.fsm = adc_seq_pkg::ST_IDLE;
        end
      end
      adc_seq_pkg::ST_IDLE: begin
        n.chan = s.insel;
        if (can_start && trig_rise) begin
          n.fsm = adc_seq_pkg::ST_SAMPLE;
          n.cnt = 8'(sample_cycles(s.sht) - 8'h01);
          n.lock = msc_active;
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (s.shp) begin
          if (s.cnt == 8'h00) begin
            n.fsm = adc_seq_pkg::ST_CONVERT;
            n.cnt = 8'(adc_seq_pkg::CONV_TOTAL - 8'h01);
            n.sw = 1'b0;
          end else begin
            n.cnt = 8'(s.cnt - 8'h01);
          end
        end else if (trig_fall) begin
          n.fsm = adc_seq_pkg::ST_CONVERT;
          n.cnt = 8'(adc_seq_pkg::CONV_TOTAL - 8'h01);
          n.sw = 1'b0;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        n.cnt = 8'(s.cnt - 8'h01);
        if (s.cnt == 8'h00) begin
          n.result = sar_result;
          n.ready = 1'b1;
          if (!last_step) begin
            n.chan = 4'(s.chan - 4'h1);
            n.fsm = msc_active ? adc_seq_pkg::ST_SAMPLE
                               : adc_seq_pkg::ST_WAIT;
            n.cnt = 8'(sample_cycles(s.sht) - 8'h01);
          end else if (!s.mode[1]) begin
            // Single conversion or single sequence is complete.
            n.fsm = adc_seq_pkg::ST_IDLE;
            n.lock = 1'b0;
            n.armed = 1'b0;
          end else if (s.enc && msc_active) begin
            // Repeat modes restart on their own under multiple sampling.
            n.fsm = adc_seq_pkg::ST_SAMPLE;
            n.chan = s.insel;
            n.cnt = 8'(sample_cycles(s.sht) - 8'h01);
          end else begin
            // Repeat modes wait for the next trigger, or stop if disabled.
            n.fsm = adc_seq_pkg::ST_IDLE;
          end
        end
      end
      adc_seq_pkg::ST_WAIT: begin
        // Mid-sequence steps are taken by plain trigger edges.
        if (trig_rise) begin
          n.fsm = adc_seq_pkg::ST_SAMPLE;
          n.cnt = 8'(sample_cycles(s.sht) - 8'h01);
        end
      end
      default: begin
        n.fsm = adc_seq_pkg::ST_OFF;
      end
    endcase
    if (abort) begin
      n.fsm = s.on ? adc_seq_pkg::ST_IDLE : adc_seq_pkg::ST_OFF;
      n.lock = 1'b0;
      n.chan = s.insel;
    end
    // Register reads are prepared in the first access cycle.
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        adc_seq_pkg::OFS_CTRL0: begin
          n.prdata[adc_seq_pkg::BIT_ON] = s.on;
          n.prdata[adc_seq_pkg::BIT_ENC] = s.enc;
          n.prdata[adc_seq_pkg::BIT_SW] = s.sw;
          n.prdata[adc_seq_pkg::BIT_MSC] = s.msc;
          n.prdata[adc_seq_pkg::POS_SHT +: 4] = s.sht;
        end
        adc_seq_pkg::OFS_CTRL1: begin
          n.prdata[adc_seq_pkg::POS_MODE +: 2] = s.mode;
          n.prdata[adc_seq_pkg::BIT_SHP] = s.shp;
          n.prdata[adc_seq_pkg::BIT_INV] = s.inv;
          n.prdata[adc_seq_pkg::POS_SRC +: 2] = s.src;
          n.prdata[adc_seq_pkg::BIT_BUSY] = s.busy;
        end
        adc_seq_pkg::OFS_CHAN: begin
          n.prdata[adc_seq_pkg::POS_INSEL +: 4] = s.insel;
          n.prdata[adc_seq_pkg::POS_PTR +: 4] = s.chan;
        end
        adc_seq_pkg::OFS_RESULT: begin
          n.prdata[9:0] = s.result;
        end
        adc_seq_pkg::OFS_FLAGS: begin
          n.prdata[adc_seq_pkg::BIT_READY] = s.ready;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
    // Reading the result clears its flag unless a new result lands now.
    if (rd_done && paddr == adc_seq_pkg::OFS_RESULT && !landing) begin
      n.ready = 1'b0;
    end
    // Writes take effect at the completing edge of the access.
    if (wr_done) begin
      case (paddr)
        adc_seq_pkg::OFS_CTRL0: begin
          n.on = pwdata[adc_seq_pkg::BIT_ON];
          n.enc = pwdata[adc_seq_pkg::BIT_ENC];
          if (pwdata[adc_seq_pkg::BIT_SW]) begin
            n.sw = 1'b1;
          end
          if (!s.enc) begin
            n.msc = pwdata[adc_seq_pkg::BIT_MSC];
            n.sht = pwdata[adc_seq_pkg::POS_SHT +: 4];
          end
        end
        adc_seq_pkg::OFS_CTRL1: begin
          // Mode may always be forced to zero so that activity can stop.
          if (!s.enc || pwdata[adc_seq_pkg::POS_MODE +: 2] == 2'h0) begin
            n.mode = pwdata[adc_seq_pkg::POS_MODE +: 2];
          end
          if (!s.enc) begin
            n.shp = pwdata[adc_seq_pkg::BIT_SHP];
            n.inv = pwdata[adc_seq_pkg::BIT_INV];
            n.src = pwdata[adc_seq_pkg::POS_SRC +: 2];
          end
        end
        adc_seq_pkg::OFS_CHAN: begin
          if (!s.enc) begin
            n.insel = pwdata[adc_seq_pkg::POS_INSEL +: 4];
          end
        end
        adc_seq_pkg::OFS_FLAGS: begin
          // A result landing in this cycle wins over the clear.
          if (pwdata[adc_seq_pkg::BIT_READY] && !landing) begin
            n.ready = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Sampling output: timer driven in pulse mode, trigger level otherwise.
    if (s.shp) begin
      n.samp = n.fsm == adc_seq_pkg::ST_SAMPLE;
    end else begin
      n.samp = sample_trigger_input && n.fsm != adc_seq_pkg::ST_OFF &&
               n.fsm != adc_seq_pkg::ST_CONVERT &&
               (s.enc || n.fsm == adc_seq_pkg::ST_SAMPLE);
    end
    n.connect = n.samp ? onehot(n.chan) : 16'h0000;
    n.conv = n.fsm == adc_seq_pkg::ST_CONVERT;
    n.busy = n.fsm == adc_seq_pkg::ST_SAMPLE ||
             n.fsm == adc_seq_pkg::ST_CONVERT ||
             n.fsm == adc_seq_pkg::ST_WAIT;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fsm <= adc_seq_pkg::ST_OFF;
      s.sht <= adc_seq_pkg::RST_SHT;
      s.insel <= adc_seq_pkg::RST_INSEL;
      s.armed <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign sample_control = s.samp;
  assign channel_connect = s.connect;
  assign conversion_active = s.conv;
  assign result_ready_flag = s.ready;
  assign busy = s.busy;

  // Checks on the controller behaviour.
  chk_connect_iso: assert property (@(posedge pclk) disable iff (!presetn)
    !s.samp |-> s.connect == 16'h0000)
    else $error("input connected while not sampling");

  chk_connect_one: assert property (@(posedge pclk) disable iff (!presetn)
    s.samp |-> s.connect == onehot(s.chan))
    else $error("wrong input connected while sampling");

  chk_conv_length: assert property (@(posedge pclk)
    disable iff (!presetn || abort)
    $rose(s.conv) |-> s.conv[*8] ##1 s.conv[*4] ##1 !s.conv)
    else $error("conversion did not last twelve clocks");

  chk_result_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(s.fsm) == adc_seq_pkg::ST_CONVERT && $past(s.cnt) == 8'h00 &&
     $past(s.on) && !$past(abort)) |-> s.ready &&
     s.result == $past(sar_result))
    else $error("result not stored with ready flag");

  chk_timer_hold: assert property (@(posedge pclk)
    disable iff (!presetn || abort)
    (s.fsm == adc_seq_pkg::ST_SAMPLE && s.shp && s.cnt != 8'h00)
    |=> s.samp && s.fsm == adc_seq_pkg::ST_SAMPLE)
    else $error("sampling timer ended early");

  chk_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(s.fsm) == adc_seq_pkg::ST_SAMPLE &&
     s.fsm == adc_seq_pkg::ST_CONVERT && !$past(wr_done)) |-> !s.sw)
    else $error("software start not cleared");

  chk_enc_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.busy) |-> $past(s.enc) && s.chan == $past(s.insel))
    else $error("start without enable or channel reload");

  chk_off_state: assert property (@(posedge pclk) disable iff (!presetn)
    !s.on |=> s.fsm == adc_seq_pkg::ST_OFF && !s.busy)
    else $error("controller not off after converter off");

  chk_seq_down: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(s.fsm) == adc_seq_pkg::ST_CONVERT &&
     s.fsm == adc_seq_pkg::ST_WAIT) |-> s.chan == 4'($past(s.chan) - 4'h1))
    else $error("sequence pointer did not step down");

  chk_hard_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == adc_seq_pkg::MODE_SINGLE && !s.enc) |=> !s.busy)
    else $error("activity continued after hard stop");

  chk_ext_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (!s.shp && s.fsm == adc_seq_pkg::ST_SAMPLE && $stable(s.shp))
    |-> s.samp == $past(sample_trigger_input))
    else $error("sampling does not follow trigger level");

  // Flag priority and the stop points of each mode.
  chk_ready_wins: assert property (@(posedge pclk)
    disable iff (!presetn) landing |=> s.ready)
    else $error("result ready flag lost to a clear");

  chk_msc_chain: assert property (@(posedge pclk)
    disable iff (!presetn || abort)
    (msc_active && landing && !last_step) |=> s.fsm == adc_seq_pkg::ST_SAMPLE)
    else $error("chained conversion did not start");

  chk_seq_stop: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s.mode == adc_seq_pkg::MODE_SEQ && landing && s.chan == 4'h0)
    |=> !s.busy)
    else $error("single sequence did not stop after lowest channel");

  chk_rep_stop: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s.mode == adc_seq_pkg::MODE_REP_SINGLE && !s.enc && landing)
    |=> !s.busy)
    else $error("repeat single did not stop after its conversion");

  chk_rep_seq_end: assert property (@(posedge pclk)
    disable iff (!presetn || abort)
    (s.mode == adc_seq_pkg::MODE_REP_SEQ && landing && s.chan == 4'h0 &&
     !msc_active) |=> s.fsm == adc_seq_pkg::ST_IDLE)
    else $error("repeat sequence did not wait after lowest channel");

  chk_abort_now: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s.busy && s.mode == adc_seq_pkg::MODE_SINGLE && !s.enc)
    |=> !s.busy && !s.samp)
    else $error("single mode conversion not aborted at once");

  cov_single_done: cover property (@(posedge pclk) disable iff (!presetn)
    s.mode == adc_seq_pkg::MODE_SINGLE && $fell(s.busy) && s.ready);

  cov_seq_wait: cover property (@(posedge pclk) disable iff (!presetn)
    s.fsm == adc_seq_pkg::ST_WAIT ##[1:100] s.fsm == adc_seq_pkg::ST_SAMPLE);

  cov_msc_chain: cover property (@(posedge pclk) disable iff (!presetn)
    msc_active && s.fsm == adc_seq_pkg::ST_CONVERT
    ##1 s.fsm == adc_seq_pkg::ST_SAMPLE);

  cov_abort: cover property (@(posedge pclk) disable iff (!presetn)
    s.conv && abort);

endmodule

// ==== verilog/adc_seq_pkg.sv ====
// Constants, field layouts, state encodings and the state record of the
// sample and sequence controller of a 10-bit SAR converter.
// Assumes one APB clock that also serves as the conversion clock.
//
// How it works
// - Extended mode: trigger level drives sampling directly.
// - Extended mode: synced falling edge starts conversion.
// - Pulse mode: trigger edge starts the sampling timer.
// - Timer holds sampling for interval after sync.
// - Sample time field sets interval in clocks.
// - Software start bit clears itself.
// - Inputs isolated unless sampling; then only selected.
// - Every result written, sets result ready flag.
// - Mode field selects single, sequence, repeat variants.
// - Single and sequence modes: non-software triggers need enable toggle before a restart.
// - Clearing converter on returns to off state.
// - Sequences count down from selected channel to lowest.
// - Single sequence stops after lowest channel.
// - Repeat single converts selected channel again and again.
// - Repeat sequence restarts from selected channel on trigger.
// - Multiple sample convert chains conversions automatically.
// - Multiple sample convert ignores triggers until done/toggle.
// - Enable clear in single mode aborts at once.
// - Enable clear in repeat single stops after conversion.
// - Enable clear in sequence modes stops after sequence.
// - Mode zero plus enable clear stops immediately.
// - Conversion lasts eleven clocks plus one comparator clock.
// - Trigger rising edge starts; invert bit flips polarity.
// - Nothing starts without enable; settings locked while enabled.
package adc_seq_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CHAN = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;

  // Control word 0 fields.
  localparam int BIT_ON = 0;
  localparam int BIT_ENC = 1;
  localparam int BIT_SW = 2;
  localparam int BIT_MSC = 3;
  localparam int POS_SHT = 4;
  // Control word 1 fields.
  localparam int POS_MODE = 0;
  localparam int BIT_SHP = 2;
  localparam int BIT_INV = 3;
  localparam int POS_SRC = 4;
  localparam int BIT_BUSY = 8;
  // Channel word fields.
  localparam int POS_INSEL = 0;
  localparam int POS_PTR = 8;
  // Flag word fields.
  localparam int BIT_READY = 0;

  // Trigger source code for the software start bit.
  localparam logic [1:0] SRC_SOFTWARE = 2'h0;
  // Conversion timing in conversion clock cycles.
  localparam logic [7:0] CONV_CYCLES = 8'h0b;
  localparam logic [7:0] CMP_CYCLES = 8'h01;
  localparam logic [7:0] CONV_TOTAL = CONV_CYCLES + CMP_CYCLES;
  // Sampling clocks per step of the sample time field.
  localparam logic [7:0] SHT_STEP = 8'h04;
  // Mode field values.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] MODE_REP_SINGLE = 2'h2;
  localparam logic [1:0] MODE_REP_SEQ = 2'h3;
  // Reset values.
  localparam logic [3:0] RST_SHT = 4'h0;
  localparam logic [3:0] RST_INSEL = 4'h0;

  // Controller states, Gray coded along off, idle, sample, convert, wait.
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_IDLE = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_CONVERT = 3'h2,
    ST_WAIT = 3'h6
  } fsm_t;

  // Whole state of the controller.
  typedef struct packed {
    fsm_t fsm;
    logic on;
    logic enc;
    logic sw;
    logic msc;
    logic [3:0] sht;
    logic [1:0] mode;
    logic shp;
    logic inv;
    logic [1:0] src;
    logic [3:0] insel;
    logic [9:0] result;
    logic ready;
    logic [3:0] chan;
    logic [7:0] cnt;
    logic ts1;
    logic ts2;
    logic ts3;
    logic lock;
    logic armed;
    logic samp;
    logic [15:0] connect;
    logic conv;
    logic busy;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

endpackage

// ==== tb/sar_core_model.sv ====
// Behavioural model of the analog SAR core, the input multiplexer and the
// timer trigger sources that face the sequence controller.
// Assumes the bench commands trigger levels through trig_cmd.
`timescale 1ns/1ps
module sar_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire logic sample_control,
  input wire logic [15:0] channel_connect,
  input wire logic conversion_active,
  output logic [9:0] sar_result,
  // Trigger sources
  input wire logic [2:0] trig_cmd,
  output logic [2:0] timer_trigger
);
  logic [3:0] ch_q;
  logic [9:0] noise_q;

  // Captures the connected channel and registers the timer outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_q <= 4'h0;
      noise_q <= 10'h155;
      timer_trigger <= 3'h0;
    end else begin
      noise_q <= ~noise_q + 10'h001;
      timer_trigger <= trig_cmd;
      for (int i = 0; i < 16; i++) begin
        if (sample_control && channel_connect[i]) begin
          ch_q <= 4'(i);
        end
      end
    end
  end

  // The result is meaningful only while converting; otherwise it churns.
  assign sar_result = conversion_active ? {ch_q, 6'h2d} : noise_q;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the sample and sequence controller.
// Assumes the SAR model of sar_core_model.sv and an APB master here.
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic sample_control, conversion_active, result_ready_flag, busy;
  logic samp_p, conv_p;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [2:0] timer_trigger, trig_cmd;
  logic [9:0] sar_result;
  logic [15:0] channel_connect;
  int err_count, n_checks, n_conv, samp_len, conv_len, gap, lsamp, lconv;
  int lgap, k, s, c, t;
  int chq[$];

  adc_seq_ctrl i_adc_seq_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_trigger(timer_trigger), .sar_result(sar_result),
    .sample_control(sample_control), .channel_connect(channel_connect),
    .conversion_active(conversion_active),
    .result_ready_flag(result_ready_flag), .busy(busy));

  sar_core_model i_sar_core_model (.pclk(pclk), .presetn(presetn),
    .sample_control(sample_control), .channel_connect(channel_connect),
    .conversion_active(conversion_active), .sar_result(sar_result),
    .trig_cmd(trig_cmd), .timer_trigger(timer_trigger));

  // Makes the 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Records sampled channels, sample lengths and conversion lengths.
  always @(posedge pclk) begin
    gap++;
    if (sample_control === 1'b1) begin
      samp_len++;
      if (samp_p !== 1'b1) begin
        for (int i = 0; i < 16; i++) begin
          if (channel_connect[i] === 1'b1) chq.push_back(i);
        end
      end
    end else if (samp_p === 1'b1) begin
      lsamp = samp_len;
      samp_len = 0;
      gap = 0;
    end
    if (sample_control === 1'b0) chk(32'(channel_connect), 0);
    if (conversion_active === 1'b1) begin
      if (conv_p !== 1'b1) lgap = gap;
      conv_len++;
    end else if (conv_p === 1'b1) begin
      lconv = conv_len;
      conv_len = 0;
      n_conv++;
    end
    samp_p = sample_control;
    conv_p = conversion_active;
  end

  // Compares one value and counts the outcome.
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(0, 1);
  endtask

  // Reads a register and compares it with the expected word.
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Programs the controller with enable low, then sets enable.
  task cfg(input int m, shp, inv, src, sel, msc, sht);
    c0 = 32'(1 | msc << 3 | sht << 4);
    apb(1'b1, 8'h00, c0);
    apb(1'b1, 8'h04, 32'(m | shp << 2 | inv << 3 | src << 4));
    apb(1'b1, 8'h08, 32'(sel));
    c0 = c0 | 32'h2;
    apb(1'b1, 8'h00, c0);
  endtask

  // Waits until the conversion count reaches n, then settles.
  task wait_n(input int n);
    int w;
    w = 0;
    while (n_conv < n && w < 4000) begin
      @(posedge pclk);
      w++;
    end
    chk(32'(n_conv >= n), 1);
    repeat (3) @(posedge pclk);
  endtask

  // Drives one timer source high for n cycles.
  task pulse(input int i, input int n);
    @(posedge pclk);
    trig_cmd[i] <= 1'b1;
    repeat (n) @(posedge pclk);
    trig_cmd[i] <= 1'b0;
  endtask

  // Prints the verdict and ends the run.
  task end_sim();
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge pclk);
    chk(0, 1);
    end_sim();
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(87072));
    {psel, penable, pwrite, paddr, pwdata, trig_cmd} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 5; k++) rc(8'(k * 4), 0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(er), 1);
    chk(rd, 0);
    // Software single conversion with pulse sampling.
    s = $urandom % 4;
    c = $urandom % 16;
    cfg(0, 1, 0, 0, c, 0, s);
    apb(1'b1, 8'h00, c0 | 32'h4);
    wait_n(1);
    chk(32'(result_ready_flag), 1);
    chk(32'(lsamp), 32'(4 * (s + 1)));
    chk(32'(lconv), 12);
    chk(32'(chq.pop_front()), 32'(c));
    rc(8'h10, 1);
    rc(8'h0c, 32'({4'(c), 6'h2d}));
    rc(8'h10, 0);
    chk(32'(result_ready_flag), 0);
    rc(8'h00, c0);
    apb(1'b1, 8'h08, 32'(c ^ 1));
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'hf, 32'(c));
    apb(1'b1, 8'h00, c0 | 32'h4);
    wait_n(2);
    chk(32'(chq.pop_front()), 32'(c));
    // Chained sequence down from channel three.
    cfg(1, 1, 0, 0, 3, 1, 0);
    apb(1'b1, 8'h00, c0 | 32'h4);
    wait_n(6);
    for (k = 3; k >= 0; k--) chk(32'(chq.pop_front()), 32'(k));
    repeat (30) @(posedge pclk);
    chk(32'({busy, 8'(n_conv)}), 32'h6);
    apb(1'b1, 8'h10, 32'h1);
    rc(8'h10, 0);
    rc(8'h0c, 32'h2d);
    rc(8'h08, 32'h303);
    // Timer single conversion needs an enable toggle.
    cfg(0, 1, 0, 1, 2, 0, 0);
    pulse(0, 2);
    wait_n(7);
    pulse(0, 2);
    repeat (60) @(posedge pclk);
    chk(32'(n_conv), 7);
    apb(1'b1, 8'h00, 32'h1);
    pulse(0, 2);
    repeat (60) @(posedge pclk);
    chk(32'(n_conv), 7);
    chk(32'(chq.pop_front()), 2);
    // Repeat single with chaining, stopped by enable clear.
    cfg(2, 1, 0, 2, 5, 1, 0);
    pulse(1, 2);
    wait_n(10);
    pulse(1, 2);
    t = n_conv;
    apb(1'b1, 8'h00, 32'h9);
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    repeat (40) @(posedge pclk);
    chk(32'(n_conv - t <= 1 && busy === 1'b0), 1);
    while (chq.size() > 0) chk(32'(chq.pop_front()), 5);
    // Repeat sequence stepped by triggers, then stopped at once.
    cfg(3, 1, 0, 3, 1, 0, 0);
    for (k = 0; k < 2; k++) begin
      t = n_conv + 1;
      pulse(2, 2);
      wait_n(t);
    end
    pulse(2, 2);
    k = 0;
    while (conversion_active !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    apb(1'b1, 8'h04, 32'h34);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(busy), 0);
    for (k = 0; k < 3; k++) chk(32'(chq.pop_front()), 32'(1 - k % 2));
    // Extended sampling follows the trigger level.
    cfg(0, 0, 0, 1, 4, 0, 0);
    t = n_conv + 1;
    pulse(0, 7);
    wait_n(t);
    chk(32'(lsamp), 7);
    chk(32'(lgap >= 1 && lgap <= 4), 1);
    chk(32'(chq.pop_front()), 4);
    // Inverted trigger starts on the source falling edge.
    cfg(0, 1, 1, 1, 6, 0, 0);
    t = n_conv + 1;
    pulse(0, 3);
    wait_n(t);
    chk(32'(chq.pop_front()), 6);
    // Converter off, then enable clear, during a long sample.
    for (k = 0; k < 2; k++) begin
      cfg(0, 1, 0, 0, 0, 0, 15);
      apb(1'b1, 8'h00, c0 | 32'h4);
      s = 0;
      while (sample_control !== 1'b1 && s < 200) begin
        @(posedge pclk);
        s++;
      end
      rc(8'h04, 32'h104);
      apb(1'b1, 8'h00, k ? 32'hf1 : 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'({busy, sample_control}), 0);
      chq.delete();
    end
    end_sim();
  end
endmodule
